// [src/rx_sync_alarm_outputs.sv]
`timescale 1ns/1ps
`include "rx_out_params.svh"

module rx_sync_alarm_outputs
	import rx_out_pkg::*;
(
	input wire logic clk_i,                  // 10 MHz system clock
	input wire logic rst_b_i,                // Async reset, active low
	input wire rx_mode_t mode_i,             // Line mode, one-hot
	input wire rx_cfg_t cfg_i,               // Static configuration bits
	input wire logic rx_line_clk_i,          // Recovered line clock, foreign domain
	input wire logic rx_line_data_i,         // Recovered line data, foreign domain
	input wire rx_frm_t frm_i,               // Framer indications, foreign domain
	input wire logic tx_clock_in_i,          // Transmit clock pin, foreign domain
	output logic rx_clk_o,                   // Recovered receive clock out
	output logic rx_boundary_pulse_o,        // Frame or multiframe sync pulse
	output logic rx_nrz_out_o,               // NRZ serial receive data
	output logic rx_frame_loss_out_o,        // Frame loss or transmit clock loss
	output logic rx_signal_loss_out_o,       // Loss of signal
	output logic rx_alarm_indication_out_o,  // Blue alarm or AIS
	output rx_oe_t oe_o                      // Output enables, high while driven
);

	localparam int SYNC_W = 9;

	// ************************************************************
	// Decoding helpers
	// ************************************************************
	function automatic logic is_framed(input rx_mode_t m);
		is_framed = (m == MODE_T1) || (m == MODE_E1);
	endfunction : is_framed

	function automatic logic is_rise(input logic cur, input logic prev);
		is_rise = cur & ~prev;
	endfunction : is_rise

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [SYNC_W-1:0] async_in;
	logic [SYNC_W-1:0] meta_reg;
	logic [SYNC_W-1:0] sync_reg;

	assign async_in = {rx_line_clk_i, rx_line_data_i, tx_clock_in_i, frm_i};

	generate
		for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
			always_ff @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					meta_reg[i] <= 1'b0;
					sync_reg[i] <= 1'b0;
				end else begin
					meta_reg[i] <= async_in[i];
					sync_reg[i] <= meta_reg[i];
				end
			end
		end
	endgenerate

	logic line_clk_s;
	logic line_data_s;
	logic tx_clk_s;
	rx_frm_t frm_s;

	assign line_clk_s = sync_reg[8];
	assign line_data_s = sync_reg[7];
	assign tx_clk_s = sync_reg[6];
	assign frm_s = rx_frm_t'(sync_reg[5:0]);

	// ************************************************************
	// Recovered clock and edge detection
	// ************************************************************
	// Sampling at 10 MHz follows T1/E1 clocks; a true 6312kHz clock is
	// above what this sampler can resolve, so that mode uses time counts.
	logic rclk_reg;
	logic line_rise;

	assign line_rise = is_rise(line_clk_s, rclk_reg);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rclk_reg <= 1'b0;
		end else begin
			rclk_reg <= line_clk_s;
		end
	end

	// ************************************************************
	// Serial data
	// ************************************************************
	logic nrz_reg;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			nrz_reg <= 1'b0;
		end else if (line_rise) begin
			nrz_reg <= line_data_s;
		end
	end

	// ************************************************************
	// Sync pulse
	// ************************************************************
	logic pulse_reg;
	logic extend_reg;
	logic mark;
	logic widen;

	assign mark = cfg_i.multiframe_sel ? frm_s.multiframe_mark : frm_s.frame_mark;
	assign widen = (mode_i == MODE_T1) && !cfg_i.multiframe_sel && cfg_i.double_wide_sig
		&& frm_s.sig_frame;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pulse_reg <= 1'b0;
			extend_reg <= 1'b0;
		end else if (!is_framed(mode_i)) begin
			pulse_reg <= 1'b0;
			extend_reg <= 1'b0;
		end else if (line_rise) begin
			if (mark) begin
				pulse_reg <= 1'b1;
				extend_reg <= widen;
			end else if (extend_reg) begin
				pulse_reg <= 1'b1;
				extend_reg <= 1'b0;
			end else begin
				pulse_reg <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Transmit clock watchdog
	// ************************************************************
	logic [2:0] div_reg;
	logic mclk_tick;
	logic tx_prev_reg;
	logic [3:0] quiet_reg;
	logic tx_loss_reg;

	assign mclk_tick = (div_reg == `SCALED_MCLK_DIV - 3'h1);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_reg <= 3'h0;
		end else if (mclk_tick) begin
			div_reg <= 3'h0;
		end else begin
			div_reg <= div_reg + 3'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_prev_reg <= 1'b0;
			quiet_reg <= 4'h0;
			tx_loss_reg <= 1'b0;
		end else begin
			tx_prev_reg <= tx_clk_s;
			if (tx_clk_s != tx_prev_reg) begin
				quiet_reg <= 4'h0;
				tx_loss_reg <= 1'b0;
			end else if (mclk_tick && quiet_reg != `TX_CLK_LOSS_PERIODS) begin
				quiet_reg <= quiet_reg + 4'h1;
			end else if (quiet_reg == `TX_CLK_LOSS_PERIODS) begin
				tx_loss_reg <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Frame loss output
	// ************************************************************
	logic frame_loss_reg;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			frame_loss_reg <= 1'b0;
		end else if (cfg_i.tx_clock_loss_mode) begin
			frame_loss_reg <= tx_loss_reg;
		end else begin
			frame_loss_reg <= frm_s.hunting;
		end
	end

	// ************************************************************
	// Signal loss
	// ************************************************************
	logic [7:0] zero_cnt_reg;
	logic [`RX_LOS_SYNC_CNT_W-1:0] zero_time_reg;
	logic los_reg;
	logic [7:0] zero_limit;

	assign zero_limit = (mode_i == MODE_T1) ? `RX_ZERO_LIMIT_T1 : `RX_ZERO_LIMIT_E1;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			zero_cnt_reg <= 8'h00;
		end else if (!is_framed(mode_i)) begin
			zero_cnt_reg <= 8'h00;
		end else if (line_rise) begin
			if (line_data_s) begin
				zero_cnt_reg <= 8'h00;
			end else if (zero_cnt_reg != 8'hFF) begin
				zero_cnt_reg <= zero_cnt_reg + 8'h01;
			end
		end
	end

	// Counts system cycles, so it works without any recovered clock edge
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			zero_time_reg <= '0;
		end else if (mode_i != MODE_SYNC6312 || line_data_s) begin
			zero_time_reg <= '0;
		end else if (zero_time_reg != `RX_LOS_SYNC_CNT_W'(`RX_LOS_SYNC_CYC)) begin
			zero_time_reg <= zero_time_reg + `RX_LOS_SYNC_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			los_reg <= 1'b0;
		end else if (is_framed(mode_i)) begin
			los_reg <= (zero_cnt_reg >= zero_limit);
		end else begin
			los_reg <= (zero_time_reg == `RX_LOS_SYNC_CNT_W'(`RX_LOS_SYNC_CYC));
		end
	end

	// ************************************************************
	// Alarm indication
	// ************************************************************
	logic alarm_reg;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			alarm_reg <= 1'b0;
		end else begin
			case (mode_i)
				MODE_T1: begin
					alarm_reg <= frm_s.blue_alarm;
				end
				MODE_E1: begin
					alarm_reg <= frm_s.ais;
				end
				default: begin
					alarm_reg <= 1'b0;
				end
			endcase
		end
	end

	// ************************************************************
	// Output enables
	// ************************************************************
	rx_oe_t oe_reg;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			oe_reg <= '0;
		end else begin
			oe_reg <= {4{is_framed(mode_i)}};
		end
	end

	assign rx_clk_o = rclk_reg;
	assign rx_boundary_pulse_o = pulse_reg;
	assign rx_nrz_out_o = nrz_reg;
	assign rx_frame_loss_out_o = frame_loss_reg;
	assign rx_signal_loss_out_o = los_reg;
	assign rx_alarm_indication_out_o = alarm_reg;
	assign oe_o = oe_reg;

endmodule : rx_sync_alarm_outputs

// [src/rx_out_params.svh]
`ifndef RX_OUT_PARAMS_SVH
`define RX_OUT_PARAMS_SVH

// Consecutive received zeros that declare signal loss
`define RX_ZERO_LIMIT_T1 8'hC0
`define RX_ZERO_LIMIT_E1 8'hFF

// Signal-loss time in the 6312kHz mode
`define RX_CLK_PERIOD_NS 100
`define RX_LOS_SYNC_TIME_NS 65000
`define RX_LOS_SYNC_CYC ((`RX_LOS_SYNC_TIME_NS) / (`RX_CLK_PERIOD_NS))
`define RX_LOS_SYNC_CNT_W 10

// Transmit-clock watchdog
`define TX_CLK_LOSS_PERIODS 4'hF
`define SCALED_MCLK_DIV 3'h5

`endif

// [src/rx_out_pkg.sv]
package rx_out_pkg;

	typedef enum logic [2:0] {
		MODE_T1 = 3'b001,
		MODE_E1 = 3'b010,
		MODE_SYNC6312 = 3'b100
	} rx_mode_t;

	typedef struct packed {
		logic multiframe_sel;
		logic double_wide_sig;
		logic tx_clock_loss_mode;
	} rx_cfg_t;

	typedef struct packed {
		logic frame_mark;
		logic multiframe_mark;
		logic sig_frame;
		logic hunting;
		logic blue_alarm;
		logic ais;
	} rx_frm_t;

	typedef struct packed {
		logic boundary;
		logic nrz;
		logic frame_loss;
		logic alarm;
	} rx_oe_t;

endpackage : rx_out_pkg

// [testbench/rx_out_checker.sv]
`timescale 1ns/1ps
module rx_out_checker
	import rx_out_pkg::*;
(
	input wire logic clk_i, // Clock
	input wire logic rst_b_i, // Reset
	input wire rx_mode_t mode_i, // Mode
	input wire rx_cfg_t cfg_i, // Config
	input wire rx_frm_t frm_i, // Framer
	input wire logic tx_clock_in_i, // Tx clock
	input wire logic rx_clk_o, // Rx clock
	input wire logic rx_boundary_pulse_o, // Sync
	input wire logic rx_nrz_out_o, // Data
	input wire logic rx_frame_loss_out_o, // Frame loss
	input wire logic rx_signal_loss_out_o, // Signal loss
	input wire logic rx_alarm_indication_out_o, // Alarm
	input wire rx_oe_t oe_o // Enables
);
	logic [6:0] idle_reg;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// Saturates, so a long stall cannot wrap back into the quiet window
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) idle_reg <= 7'h00;
		else if ($changed(tx_clock_in_i)) idle_reg <= 7'h00;
		else if (idle_reg != 7'h7F) idle_reg <= idle_reg + 7'h01;
	end
	// ****
	// Checks
	// ****
	a_oe_float: assert property (mode_i == MODE_SYNC6312 |=> oe_o == 4'h0) else $error("oe on");
	a_oe_drive: assert property (mode_i != MODE_SYNC6312 |=> oe_o == 4'hF) else $error("oe off");
	a_nrz_edge: assert property ($changed(rx_nrz_out_o) |-> $rose(rx_clk_o)) else $error("data moved");
	a_sync_edge: assert property ($changed(rx_boundary_pulse_o) |-> $rose(rx_clk_o)) else $error("sync moved");
	a_blue_alarm: assert property ((mode_i == MODE_T1 && frm_i.blue_alarm) [*4] |-> rx_alarm_indication_out_o)
		else $error("no blue");
	a_ais_alarm: assert property ((mode_i == MODE_E1 && frm_i.ais) [*4] |-> rx_alarm_indication_out_o)
		else $error("no ais");
	a_hunt_loss: assert property ((!cfg_i.tx_clock_loss_mode && frm_i.hunting) [*4] |-> rx_frame_loss_out_o)
		else $error("no hunt");
	a_tx_lost: assert property (cfg_i.tx_clock_loss_mode && idle_reg == 7'h5F |-> rx_frame_loss_out_o)
		else $error("no tx loss");
	a_tx_alive: assert property (cfg_i.tx_clock_loss_mode && idle_reg == 7'h06 |-> !rx_frame_loss_out_o)
		else $error("false tx loss");
	a_los_clear: assert property ($rose(rx_clk_o) && rx_nrz_out_o && mode_i != MODE_SYNC6312
		|-> ##[0:2] !rx_signal_loss_out_o) else $error("los stuck");
endmodule : rx_out_checker
bind rx_sync_alarm_outputs rx_out_checker chk_u (.clk_i, .rst_b_i, .mode_i, .cfg_i, .frm_i, .tx_clock_in_i,
	.rx_clk_o, .rx_boundary_pulse_o, .rx_nrz_out_o, .rx_frame_loss_out_o, .rx_signal_loss_out_o,
	.rx_alarm_indication_out_o, .oe_o);

// [testbench/rx_sink.sv]
`timescale 1ns/1ps
module rx_sink (
	input wire logic clk_i, // Clock
	input wire logic rst_b_i, // Reset
	input wire logic rclk_i, // Rx clock
	input wire logic nrz_i, // Data
	input wire logic pulse_i, // Sync
	output logic [7:0] bits_o, // Last bits
	output logic [7:0] marks_o, // Sync periods
	output logic [3:0] per_o // Clock period
);
	logic rclk_reg;
	logic [3:0] cyc_reg;
	// ****
	// Capture at each receive clock rise
	// ****
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rclk_reg <= 1'b0;
			cyc_reg <= 4'h0;
			bits_o <= 8'h00;
			marks_o <= 8'h00;
			per_o <= 4'h0;
		end else begin
			rclk_reg <= rclk_i;
			cyc_reg <= cyc_reg + 4'h1;
			if (rclk_i && !rclk_reg) begin
				cyc_reg <= 4'h1;
				per_o <= cyc_reg;
				bits_o <= {bits_o[6:0], nrz_i};
				marks_o <= marks_o + {7'h00, pulse_i};
			end
		end
	end
endmodule : rx_sink

// [testbench/rx_sync_alarm_outputs_tb.sv]
`timescale 1ns/1ps
module rx_sync_alarm_outputs_tb
	import rx_out_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	rx_mode_t mode_i = MODE_T1;
	rx_cfg_t cfg_i = 3'h0;
	rx_frm_t frm_i = 6'h00;
	logic [2:0] div = 3'h0;
	logic rx_line_clk_i;
	logic rx_line_data_i = 1'b1;
	logic tx_run = 1'b1;
	logic tx_clock_in_i = 1'b0;
	logic rx_clk_o, rx_boundary_pulse_o, rx_nrz_out_o, rx_frame_loss_out_o;
	logic rx_signal_loss_out_o, rx_alarm_indication_out_o;
	rx_oe_t oe_o;
	logic [7:0] bits, marks;
	logic [3:0] per;
	int n_fail = 0;
	int checks_done = 0;
	assign rx_line_clk_i = div[2];
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		div <= div + 3'h1;
		if (tx_run) tx_clock_in_i <= div[1];
	end
	rx_sync_alarm_outputs dut_u (.clk_i, .rst_b_i, .mode_i, .cfg_i, .rx_line_clk_i, .rx_line_data_i, .frm_i,
		.tx_clock_in_i, .rx_clk_o, .rx_boundary_pulse_o, .rx_nrz_out_o, .rx_frame_loss_out_o,
		.rx_signal_loss_out_o, .rx_alarm_indication_out_o, .oe_o);
	rx_sink sink_u (.clk_i, .rst_b_i, .rclk_i(rx_clk_o), .nrz_i(rx_nrz_out_o), .pulse_i(rx_boundary_pulse_o),
		.bits_o(bits), .marks_o(marks), .per_o(per));
	// ****
	// Helpers
	// ****
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// Changes at the line clock fall keep data and marks clear of the rise
	task automatic bit_out(input logic d, input logic fm, input logic mm, input logic sf);
		@(posedge clk_i iff div == 3'h7);
		rx_line_data_i <= d;
		frm_i.frame_mark <= fm;
		frm_i.multiframe_mark <= mm;
		frm_i.sig_frame <= sf;
	endtask : bit_out
	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	// ****
	// Scenarios
	// ****
	task automatic t_stream;
		logic [7:0] pat = 8'hA5;
		logic [7:0] m0 = marks;
		for (int i = 7; i >= 0; i--) bit_out(pat[i], i == 7, 1'b0, 1'b0);
		cyc(10);
		chk(bits, 8'hA5);
		chk(marks - m0, 8'h01);
		chk(per, 8'h08);
	endtask : t_stream
	task automatic t_mark(input rx_mode_t m, input rx_cfg_t c, input logic mm, input logic sf, input logic [7:0] n);
		logic [7:0] m0 = marks;
		mode_i <= m;
		cfg_i <= c;
		bit_out(1'b1, 1'b1, mm, sf);
		repeat (2) bit_out(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(10);
		chk(marks - m0, n);
	endtask : t_mark
	task automatic t_los(input rx_mode_t m, input logic [8:0] lim);
		mode_i <= m;
		bit_out(1'b1, 1'b0, 1'b0, 1'b0);
		repeat (lim) bit_out(1'b0, 1'b0, 1'b0, 1'b0);
		// Only lim-1 zeros have reached the counter here, so this pins the exact limit
		cyc(3);
		chk(rx_signal_loss_out_o, 8'h00);
		bit_out(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(3);
		chk(rx_signal_loss_out_o, 8'h01);
		bit_out(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(3);
		chk(rx_signal_loss_out_o, 8'h00);
	endtask : t_los
	task automatic t_sync;
		mode_i <= MODE_SYNC6312;
		cyc(5);
		chk(oe_o, 8'h00);
		rx_line_data_i <= 1'b0;
		cyc(640);
		chk(rx_signal_loss_out_o, 8'h00);
		cyc(20);
		chk(rx_signal_loss_out_o, 8'h01);
		rx_line_data_i <= 1'b1;
		cyc(6);
		chk(rx_signal_loss_out_o, 8'h00);
	endtask : t_sync
	task automatic t_alarm(input rx_mode_t m);
		mode_i <= m;
		cfg_i <= 3'h0;
		frm_i.blue_alarm <= 1'b1;
		cyc(6);
		chk(rx_alarm_indication_out_o, m == MODE_T1);
		frm_i.blue_alarm <= 1'b0;
		frm_i.ais <= 1'b1;
		frm_i.hunting <= 1'b1;
		cyc(6);
		chk(rx_alarm_indication_out_o, m == MODE_E1);
		chk(rx_frame_loss_out_o, 8'h01);
		frm_i.ais <= 1'b0;
		cfg_i <= 3'h1;
		tx_run <= 1'b0;
		cyc(70);
		chk(rx_frame_loss_out_o, 8'h00);
		frm_i.hunting <= 1'b0;
		cyc(30);
		chk(rx_frame_loss_out_o, 8'h01);
		tx_run <= 1'b1;
		cyc(8);
		chk(rx_frame_loss_out_o, 8'h00);
	endtask : t_alarm
	initial begin
		cyc(2);
		rst_b_i <= 1'b1;
		cyc(4);
		t_stream();
		t_mark(MODE_T1, 3'h0, 1'b0, 1'b1, 8'h01);
		t_mark(MODE_T1, 3'h4, 1'b0, 1'b0, 8'h00);
		t_mark(MODE_T1, 3'h6, 1'b1, 1'b1, 8'h01);
		t_mark(MODE_T1, 3'h2, 1'b0, 1'b1, 8'h02);
		t_mark(MODE_T1, 3'h2, 1'b0, 1'b0, 8'h01);
		t_mark(MODE_E1, 3'h2, 1'b0, 1'b1, 8'h01);
		t_los(MODE_T1, 9'h0C0);
		t_los(MODE_E1, 9'h0FF);
		t_sync();
		t_alarm(MODE_T1);
		t_alarm(MODE_E1);
		tally_and_finish();
	end
	initial begin
		cyc(20000);
		n_fail++;
		tally_and_finish();
	end
endmodule : rx_sync_alarm_outputs_tb
